// >>> rtl/urlb_pkg.sv
package urlb_pkg;
  // ***********************************************
  // register offsets on the three address lines
  // ***********************************************
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_ISTAT = 3'h2;
  localparam logic [2:0] OFS_LCTL = 3'h3;
  localparam logic [2:0] OFS_MCTL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // ***********************************************
  // field positions and key values
  // ***********************************************
  localparam int LCTL_DIV_BIT = 7;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int MCTL_RTS_BIT = 1;
  localparam int MCTL_DTR_BIT = 0;
  localparam int EFN_EXT_BIT = 4;
  localparam logic [7:0] LCTL_ENH_KEY = 8'hBF;
  localparam logic [7:0] IEN_EXT_MASK = 8'hF0;
  localparam logic [7:0] ISTAT_EXT_MASK = 8'h30;
  localparam logic [7:0] FCTL_EXT_MASK = 8'h30;
  localparam logic [7:0] MCTL_EXT_MASK = 8'hE0;
  localparam logic [7:0] FRAC_MASK = 8'h3F;
  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LCTL = 8'h03;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_ISTAT = 8'h01;
  localparam logic [7:0] RST_LSTAT = 8'h60;

  // host bus access
  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } urlb_bus_t;

  // modem inputs, active low as on the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } urlb_modem_t;

  typedef enum logic [2:0] {
    URLB_BANK_STD = 3'b001,
    URLB_BANK_DIV = 3'b010,
    URLB_BANK_ENH = 3'b100
  } urlb_bank_t;
endpackage

// >>> rtl/urlb_top.sv
module urlb_top #(
  parameter logic [7:0] REVISION_CODE = 8'h5A, // value arbitrary
  parameter logic [7:0] DEVICE_ID = 8'hA5 // value arbitrary
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire urlb_pkg::urlb_bus_t bus,
  output logic [7:0] rdata_q,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  output logic [7:0] tx_char_q,
  output logic tx_load_q,
  input wire logic tx_shift_out,
  output logic rx_shift_in_q,
  input wire logic [7:0] isr_in,
  input wire logic [7:0] lsr_in,
  input wire logic serial_in,
  input wire urlb_pkg::urlb_modem_t modem_pins,
  output logic serial_out_q,
  output logic rts_n_q,
  output logic dtr_n_q,
  output logic [3:0] modem_seen_q,
  output logic loopback_q,
  output logic auto_flow_en_q,
  output logic [7:0] ien_eff_q,
  output logic [7:0] fctl_eff_q,
  output logic fctl_strobe_q,
  output logic [7:0] mctl_eff_q,
  output logic [15:0] divisor_q,
  output logic [3:0] frac_q
);
  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0] lctl_q, mctl_q, ien_q, scr_q, div_lo_q, div_hi_q, frac_reg_q;
  logic [7:0] efn_q, xon1_q, xon2_q, xoff1_q, xoff2_q, rxh_q, fctl_q;
  logic [1:0] sin_sync_q;
  logic [3:0] modem_sync1_q, modem_sync2_q;
  urlb_pkg::urlb_bank_t bank;
  logic sel, rd_hit, wr_hit, ext_on, loop;

  function automatic logic [7:0] ext_gate(input logic [7:0] v, input logic [7:0] m,
                                          input logic en);
    ext_gate = en ? v : (v & ~m);
  endfunction

  assign sel = !select_n;
  assign rd_hit = sel && bus.rd;
  assign wr_hit = sel && bus.wr;
  assign ext_on = efn_q[urlb_pkg::EFN_EXT_BIT];
  assign loop = mctl_q[urlb_pkg::MCTL_LOOP_BIT];

  always_comb begin
    if (lctl_q == urlb_pkg::LCTL_ENH_KEY) begin
      bank = urlb_pkg::URLB_BANK_ENH;
    end else if (lctl_q[urlb_pkg::LCTL_DIV_BIT]) begin
      bank = urlb_pkg::URLB_BANK_DIV;
    end else begin
      bank = urlb_pkg::URLB_BANK_STD;
    end
  end

  // ***********************************************
  // register writes
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lctl_q <= urlb_pkg::RST_LCTL;
      mctl_q <= urlb_pkg::RST_ZERO;
      scr_q <= urlb_pkg::RST_ZERO;
      ien_q <= urlb_pkg::RST_ZERO;
      div_lo_q <= urlb_pkg::RST_DIV_LOW;
      div_hi_q <= urlb_pkg::RST_ZERO;
      frac_reg_q <= urlb_pkg::RST_ZERO;
      efn_q <= urlb_pkg::RST_ZERO;
      xon1_q <= urlb_pkg::RST_ZERO;
      xon2_q <= urlb_pkg::RST_ZERO;
      xoff1_q <= urlb_pkg::RST_ZERO;
      xoff2_q <= urlb_pkg::RST_ZERO;
      fctl_q <= urlb_pkg::RST_ZERO;
    end else if (wr_hit) begin
      case (bus.addr)
        urlb_pkg::OFS_LCTL: lctl_q <= bus.wdata;
        urlb_pkg::OFS_SCR: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            xoff2_q <= bus.wdata;
          end else begin
            scr_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_MCTL: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            xon1_q <= bus.wdata;
          end else begin
            mctl_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_LSTAT: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            xon2_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_MSTAT: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            xoff1_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_DATA: begin
          if (bank == urlb_pkg::URLB_BANK_DIV) begin
            div_lo_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_IEN: begin
          if (bank == urlb_pkg::URLB_BANK_DIV) begin
            div_hi_q <= bus.wdata;
          end else if (bank == urlb_pkg::URLB_BANK_STD) begin
            ien_q <= bus.wdata;
          end
        end
        urlb_pkg::OFS_ISTAT: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            efn_q <= bus.wdata;
          end else if (bank == urlb_pkg::URLB_BANK_DIV) begin
            frac_reg_q <= bus.wdata & urlb_pkg::FRAC_MASK;
          end else begin
            fctl_q <= bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ***********************************************
  // transmit load and fifo control strobe
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_char_q <= urlb_pkg::RST_ZERO;
      tx_load_q <= 1'b0;
      fctl_strobe_q <= 1'b0;
    end else begin
      tx_load_q <= wr_hit && bus.addr == urlb_pkg::OFS_DATA
                   && bank == urlb_pkg::URLB_BANK_STD;
      fctl_strobe_q <= wr_hit && bus.addr == urlb_pkg::OFS_ISTAT
                       && bank != urlb_pkg::URLB_BANK_ENH;
      if (wr_hit && bus.addr == urlb_pkg::OFS_DATA && bank == urlb_pkg::URLB_BANK_STD) begin
        tx_char_q <= bus.wdata;
      end
    end
  end

  // receive holding latch, fed by the receiver whether looped or not
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxh_q <= urlb_pkg::RST_ZERO;
    end else if (rx_valid) begin
      rxh_q <= rx_char;
    end
  end

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sin_sync_q <= 2'b11;
      modem_sync1_q <= 4'hF;
      modem_sync2_q <= 4'hF;
    end else begin
      sin_sync_q <= {sin_sync_q[0], serial_in};
      modem_sync1_q <= modem_pins;
      modem_sync2_q <= modem_sync1_q;
    end
  end

  // ***********************************************
  // loopback routing
  // ***********************************************
  // while looped, serial_out_q, rts_n_q and dtr_n_q freeze at idle/inactive so the line sees nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loopback_q <= 1'b0;
      serial_out_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      rx_shift_in_q <= 1'b1;
      modem_seen_q <= 4'hF;
      auto_flow_en_q <= 1'b0;
    end else begin
      loopback_q <= loop;
      if (loop) begin
        serial_out_q <= 1'b1;
        rts_n_q <= 1'b1;
        dtr_n_q <= 1'b1;
        rx_shift_in_q <= tx_shift_out;
        // looped modem status follows own control outputs, not the pins
        modem_seen_q <= {~mctl_q[urlb_pkg::MCTL_RTS_BIT], ~mctl_q[urlb_pkg::MCTL_DTR_BIT],
                         ~mctl_q[3], ~mctl_q[2]};
        auto_flow_en_q <= 1'b0;
      end else begin
        serial_out_q <= tx_shift_out;
        rts_n_q <= ~mctl_q[urlb_pkg::MCTL_RTS_BIT];
        dtr_n_q <= ~mctl_q[urlb_pkg::MCTL_DTR_BIT];
        // relies on the far side idling the pin high across the test
        rx_shift_in_q <= sin_sync_q[1];
        modem_seen_q <= modem_sync2_q;
        auto_flow_en_q <= efn_q[7] | efn_q[6];
      end
    end
  end

  // ***********************************************
  // effective configuration outputs
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ien_eff_q <= urlb_pkg::RST_ZERO;
      fctl_eff_q <= urlb_pkg::RST_ZERO;
      mctl_eff_q <= urlb_pkg::RST_ZERO;
      divisor_q <= {urlb_pkg::RST_ZERO, urlb_pkg::RST_DIV_LOW};
      frac_q <= 4'h0;
    end else begin
      ien_eff_q <= ext_gate(ien_q, urlb_pkg::IEN_EXT_MASK, ext_on);
      fctl_eff_q <= ext_gate(fctl_q, urlb_pkg::FCTL_EXT_MASK, ext_on);
      mctl_eff_q <= ext_gate(mctl_q, urlb_pkg::MCTL_EXT_MASK, ext_on);
      divisor_q <= {div_hi_q, div_lo_q};
      frac_q <= ext_on ? frac_reg_q[3:0] : 4'h0;
    end
  end

  // ***********************************************
  // read mux, registered: data one cycle after the strobe
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= urlb_pkg::RST_ZERO;
    end else if (rd_hit) begin
      case (bus.addr)
        urlb_pkg::OFS_DATA: begin
          if (bank == urlb_pkg::URLB_BANK_STD) begin
            rdata_q <= rxh_q;
          end else if (div_lo_q == 8'h00 && div_hi_q == 8'h00) begin
            rdata_q <= REVISION_CODE;
          end else begin
            rdata_q <= div_lo_q;
          end
        end
        urlb_pkg::OFS_IEN: begin
          if (bank == urlb_pkg::URLB_BANK_STD) begin
            rdata_q <= ext_gate(ien_q, urlb_pkg::IEN_EXT_MASK, ext_on);
          end else if (div_lo_q == 8'h00 && div_hi_q == 8'h00) begin
            rdata_q <= DEVICE_ID;
          end else begin
            rdata_q <= div_hi_q;
          end
        end
        urlb_pkg::OFS_ISTAT: begin
          if (bank == urlb_pkg::URLB_BANK_ENH) begin
            rdata_q <= efn_q;
          end else if (bank == urlb_pkg::URLB_BANK_DIV) begin
            rdata_q <= frac_reg_q;
          end else begin
            rdata_q <= ext_gate(isr_in, urlb_pkg::ISTAT_EXT_MASK, ext_on);
          end
        end
        urlb_pkg::OFS_LCTL: rdata_q <= lctl_q;
        urlb_pkg::OFS_MCTL: begin
          rdata_q <= (bank == urlb_pkg::URLB_BANK_ENH) ? xon1_q
                     : ext_gate(mctl_q, urlb_pkg::MCTL_EXT_MASK, ext_on);
        end
        urlb_pkg::OFS_LSTAT: begin
          rdata_q <= (bank == urlb_pkg::URLB_BANK_ENH) ? xon2_q : lsr_in;
        end
        urlb_pkg::OFS_MSTAT: begin
          rdata_q <= (bank == urlb_pkg::URLB_BANK_ENH) ? xoff1_q
                     : {~modem_seen_q[1], ~modem_seen_q[0], ~modem_seen_q[2],
                        ~modem_seen_q[3], 4'h0};
        end
        urlb_pkg::OFS_SCR: begin
          rdata_q <= (bank == urlb_pkg::URLB_BANK_ENH) ? xoff2_q : scr_q;
        end
        default: rdata_q <= urlb_pkg::RST_ZERO;
      endcase
    end
  end
endmodule

// >>> tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h3C; // value arbitrary
  localparam logic [7:0] DID = 8'hC3; // value arbitrary
  logic clk, rst, select_n, serial_in, rx_valid, tx_shift_out, tx_load_q, rx_shift_in_q;
  logic serial_out_q, rts_n_q, dtr_n_q, loopback_q, auto_flow_en_q, fctl_strobe_q;
  logic [7:0] rdata_q, rx_char, tx_char_q, isr_in, lsr_in, ien_eff_q, fctl_eff_q, mctl_eff_q;
  logic [15:0] divisor_q;
  logic [3:0] modem_seen_q, frac_q, seen;
  urlb_pkg::urlb_bus_t bus;
  urlb_pkg::urlb_modem_t modem_pins;
  int miscompares = 0;
  int cmp_count = 0;
  urlb_top #(.REVISION_CODE(REV), .DEVICE_ID(DID)) i_urlb_top (.clk(clk), .rst(rst),
    .select_n(select_n), .bus(bus), .rdata_q(rdata_q), .rx_char(rx_char), .rx_valid(rx_valid),
    .tx_char_q(tx_char_q), .tx_load_q(tx_load_q), .tx_shift_out(tx_shift_out),
    .rx_shift_in_q(rx_shift_in_q), .isr_in(isr_in), .lsr_in(lsr_in), .serial_in(serial_in),
    .modem_pins(modem_pins), .serial_out_q(serial_out_q), .rts_n_q(rts_n_q),
    .dtr_n_q(dtr_n_q), .modem_seen_q(modem_seen_q), .loopback_q(loopback_q),
    .auto_flow_en_q(auto_flow_en_q), .ien_eff_q(ien_eff_q), .fctl_eff_q(fctl_eff_q),
    .fctl_strobe_q(fctl_strobe_q), .mctl_eff_q(mctl_eff_q), .divisor_q(divisor_q),
    .frac_q(frac_q));
  urlb_host_model i_urlb_host_model (.clk(clk), .bus(bus), .select_n(select_n),
    .serial_in(serial_in));
  // ***************************
  // helpers
  // ***************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_urlb_host_model.access(a, 1'b0, d, 1'b0);
    // effective outputs trail the register by one more edge
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    i_urlb_host_model.access(a, 1'b1, 8'h00, 1'b0);
    chk({8'h00, rdata_q}, {8'h00, e});
  endtask
  task automatic rx_byte(input logic [7:0] c);
    @(posedge clk);
    rx_char <= c;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ***************************
  // scenarios
  // ***************************
  task automatic t_std;
    rd(urlb_pkg::OFS_LCTL, urlb_pkg::RST_LCTL);
    wr(urlb_pkg::OFS_SCR, 8'hA5);
    i_urlb_host_model.access(urlb_pkg::OFS_SCR, 1'b0, 8'h3C, 1'b1);
    rd(urlb_pkg::OFS_SCR, 8'hA5);
    wr(urlb_pkg::OFS_IEN, 8'hFF);
    chk(ien_eff_q, 16'h000F);
    rx_byte(8'h69);
    rd(urlb_pkg::OFS_DATA, 8'h69);
    wr(urlb_pkg::OFS_DATA, 8'h96);
    chk(tx_char_q, 16'h0096);
    rd(urlb_pkg::OFS_ISTAT, isr_in & ~urlb_pkg::ISTAT_EXT_MASK);
    wr(urlb_pkg::OFS_ISTAT, 8'h31);
    chk(fctl_eff_q, 16'h0001);
    rd(urlb_pkg::OFS_LSTAT, lsr_in);
  endtask
  task automatic t_div;
    wr(urlb_pkg::OFS_LCTL, 8'h80);
    wr(urlb_pkg::OFS_DATA, 8'h12);
    wr(urlb_pkg::OFS_IEN, 8'h34);
    chk(divisor_q, 16'h3412);
    rd(urlb_pkg::OFS_IEN, 8'h34);
    wr(urlb_pkg::OFS_ISTAT, 8'h2A);
    rd(urlb_pkg::OFS_ISTAT, 8'h2A);
    wr(urlb_pkg::OFS_DATA, 8'h00);
    wr(urlb_pkg::OFS_IEN, 8'h00);
    rd(urlb_pkg::OFS_DATA, REV);
    rd(urlb_pkg::OFS_IEN, DID);
    wr(urlb_pkg::OFS_LCTL, 8'h03);
    chk(ien_eff_q, 16'h000F);
  endtask
  task automatic t_enh;
    wr(urlb_pkg::OFS_LCTL, urlb_pkg::LCTL_ENH_KEY);
    wr(urlb_pkg::OFS_ISTAT, 8'hD0);
    for (int a = 4; a < 8; a++) begin
      wr(3'(a), 8'(8'h11 * a));
    end
    for (int a = 4; a < 8; a++) begin
      rd(3'(a), 8'(8'h11 * a));
    end
    rd(urlb_pkg::OFS_ISTAT, 8'hD0);
    chk({12'h000, frac_q}, 16'h000A);
    wr(urlb_pkg::OFS_LCTL, 8'h03);
    rd(urlb_pkg::OFS_SCR, 8'hA5);
    rd(urlb_pkg::OFS_MCTL, 8'h00);
    wr(urlb_pkg::OFS_IEN, 8'hFF);
    chk(ien_eff_q, 16'h00FF);
  endtask
  task automatic t_loop;
    wr(urlb_pkg::OFS_MCTL, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    chk({rts_n_q, dtr_n_q, auto_flow_en_q}, 3'b001);
    wr(urlb_pkg::OFS_MCTL, 8'h13);
    @(posedge clk);
    tx_shift_out <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({loopback_q, serial_out_q, rts_n_q, dtr_n_q, auto_flow_en_q, rx_shift_in_q},
        6'b111100);
    chk(mctl_eff_q, 16'h0013);
    seen = modem_seen_q;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      modem_pins <= 4'(i * 5);
      tx_shift_out <= i[0];
    end
    repeat (3) @(posedge clk);
    #1;
    chk(modem_seen_q, seen);
    rx_byte(8'hC3);
    rd(urlb_pkg::OFS_DATA, 8'hC3);
    wr(urlb_pkg::OFS_MCTL, 8'h03);
    repeat (4) @(posedge clk);
    #1;
    chk({loopback_q, rx_shift_in_q}, 2'b01);
  endtask
  initial begin
    rst = 1'b1;
    rx_char = 8'h00;
    rx_valid = 1'b0;
    tx_shift_out = 1'b1;
    isr_in = 8'hF1;
    lsr_in = 8'h61;
    modem_pins = '1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk(divisor_q, 16'h0001);
    t_std();
    t_div();
    t_enh();
    t_loop();
    end_sim();
  end
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule

// >>> tb/urlb_host_model.sv
module urlb_host_model (
  input wire logic clk,
  output urlb_pkg::urlb_bus_t bus,
  output logic select_n,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus = '0;
    select_n = 1'b1;
    serial_in = 1'b1;
  end
  // released lines flip so stale values cannot pass for a match
  task automatic access(input logic [2:0] a, input logic r, input logic [7:0] d,
                        input logic sn);
    @(posedge clk);
    select_n <= sn;
    bus <= '{addr: a, rd: r, wr: !r, wdata: d};
    @(posedge clk);
    select_n <= 1'b1;
    bus <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    #1;
  endtask
endmodule

// >>> tb/urlb_top_properties.sv
// ***************************
// port checker for urlb_top
// ***************************
module urlb_top_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire urlb_pkg::urlb_bus_t bus,
  input wire logic [7:0] tx_char_q,
  input wire logic tx_load_q,
  input wire logic tx_shift_out,
  input wire logic rx_shift_in_q,
  input wire logic serial_out_q,
  input wire logic rts_n_q,
  input wire logic dtr_n_q,
  input wire logic [3:0] modem_seen_q,
  input wire logic loopback_q,
  input wire logic auto_flow_en_q,
  input wire logic [7:0] ien_eff_q,
  input wire logic fctl_strobe_q,
  input wire logic [7:0] mctl_eff_q,
  input wire logic [15:0] divisor_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] lctl_q;
  logic wr_en;
  assign wr_en = !select_n && bus.wr;
  // mirror of line control: the bank is not visible at the ports
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lctl_q <= urlb_pkg::RST_LCTL;
    end else if (wr_en && bus.addr == urlb_pkg::OFS_LCTL) begin
      lctl_q <= bus.wdata;
    end
  end
  loop_pins_a: assert property (loopback_q |-> serial_out_q && rts_n_q && dtr_n_q)
    else $error("pins moved in loopback");
  loop_route_a: assert property (
    loopback_q && $past(loopback_q) |-> rx_shift_in_q == $past(tx_shift_out))
    else $error("receive input not fed from transmit output");
  loop_enter_a: assert property (
    wr_en && bus.addr == urlb_pkg::OFS_MCTL && lctl_q != urlb_pkg::LCTL_ENH_KEY
    |-> ##2 loopback_q == $past(bus.wdata[4], 2))
    else $error("loopback does not follow modem control bit");
  modem_ignore_a: assert property (
    loopback_q && $past(loopback_q) && mctl_eff_q[4] && $stable(mctl_eff_q)
    |-> $stable(modem_seen_q)) else $error("modem pins seen in loopback");
  loop_flow_a: assert property (loopback_q && mctl_eff_q[4] |-> !auto_flow_en_q)
    else $error("auto flow active in loopback");
  tx_load_a: assert property (
    wr_en && bus.addr == urlb_pkg::OFS_DATA && !lctl_q[7]
    |=> tx_load_q && tx_char_q == $past(bus.wdata)) else $error("transmit load wrong");
  tx_cause_a: assert property (
    tx_load_q |-> $past(wr_en && bus.addr == urlb_pkg::OFS_DATA))
    else $error("transmit load without selected write");
  div_low_a: assert property (
    wr_en && bus.addr == urlb_pkg::OFS_DATA && lctl_q[7] && lctl_q != urlb_pkg::LCTL_ENH_KEY
    |-> ##2 divisor_q[7:0] == $past(bus.wdata, 2)) else $error("divisor low not written");
  ien_write_a: assert property (
    wr_en && bus.addr == urlb_pkg::OFS_IEN && !lctl_q[7]
    |-> ##2 ien_eff_q[3:0] == $past(bus.wdata[3:0], 2))
    else $error("interrupt enable not written");
  fctl_write_a: assert property (
    wr_en && bus.addr == urlb_pkg::OFS_ISTAT && !lctl_q[7] |=> fctl_strobe_q)
    else $error("fifo control strobe missing");
endmodule

bind urlb_top urlb_top_properties i_urlb_top_properties (.clk(clk), .rst(rst),
  .select_n(select_n), .bus(bus), .tx_char_q(tx_char_q), .tx_load_q(tx_load_q),
  .tx_shift_out(tx_shift_out), .rx_shift_in_q(rx_shift_in_q), .serial_out_q(serial_out_q),
  .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q), .modem_seen_q(modem_seen_q), .loopback_q(loopback_q),
  .auto_flow_en_q(auto_flow_en_q), .ien_eff_q(ien_eff_q), .fctl_strobe_q(fctl_strobe_q),
  .mctl_eff_q(mctl_eff_q), .divisor_q(divisor_q));
